// [core/azp_pkg.sv]
// Package with register map, field positions, codes and timing for the axis zero position block.
package azp_pkg;
	localparam logic [7:0] ADDR_ENV_A = 8'h00;
	localparam logic [7:0] ADDR_ENV_B = 8'h04;
	localparam logic [7:0] ADDR_ENV_C = 8'h08;
	localparam logic [7:0] ADDR_SUB_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_EXT_STATUS = 8'h10;
	localparam logic [7:0] ADDR_CONTROL = 8'h14;

	localparam logic [31:0] ENV_A_RESET = 32'h0000_0000;
	localparam logic [31:0] ENV_B_RESET = 32'h0000_0000;
	localparam logic [31:0] ENV_C_RESET = 32'h0000_0000;
	localparam logic [6:0] OPCODE_RESET = 7'h00;

	localparam int ENV_A_LIMIT_DECEL = 3;
	localparam int ENV_A_ORIGIN_POL = 7;
	localparam int ENV_A_CLEAR_OUT_EN = 9;
	localparam int ENV_A_FILTER_EN = 26;
	localparam int ENV_B_INDEX_RISING = 23;
	localparam int ENV_C_TARGET_LSB = 4;
	localparam int ENV_C_COUNTER_RST_EN = 8;
	localparam int ENV_C_RETURN_USE_INDEX = 9;
	localparam int CTRL_START = 8;
	localparam int CTRL_ABORT = 9;
	localparam int SUB_BUSY = 0;
	localparam int SUB_LIMIT_POS = 12;
	localparam int SUB_LIMIT_NEG = 13;
	localparam int SUB_ORIGIN = 14;
	localparam int EXT_LIMIT_ERR = 4;
	localparam int EXT_INDEX_STATE = 10;

	localparam logic [6:0] OP_RETURN_POS = 7'h10;
	localparam logic [6:0] OP_RETURN_NEG = 7'h18;
	localparam logic [6:0] OP_LEAVE_POS = 7'h12;
	localparam logic [6:0] OP_LEAVE_NEG = 7'h1a;
	localparam logic [6:0] OP_SEARCH_POS = 7'h15;
	localparam logic [6:0] OP_SEARCH_NEG = 7'h1d;

	localparam int CLK_PERIOD_NS = 40;
	localparam int FILTER_TIME_NS = 4000;
	localparam int FILTER_CYCLES_INT = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [6:0] FILTER_CYCLES = 7'(FILTER_CYCLES_INT);

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FEED = 2'b01,
		ST_COUNT = 2'b10
	} azp_state_e;

	typedef enum logic [1:0] {
		KIND_RETURN = 2'b00,
		KIND_LEAVE = 2'b01,
		KIND_SEARCH = 2'b10,
		KIND_NONE = 2'b11
	} azp_kind_e;

	typedef struct packed {
		logic limit_sel_neg;
		logic limit_neg;
		logic limit_pos;
		logic index;
		logic origin;
	} azp_sensor_s;
endpackage

// [core/azp_top.sv]
// Axis zero position logic: sensor conditioning, operation sequencing and status registers.
//
// Notes on behaviour
// (R01) Leave-zero codes 12h and 1Ah move the axis positive and negative respectively.
// (R02) Search codes 15h and 1Dh move the axis positive and negative respectively.
// (R03) Return codes 10h and 18h feed positive or negative until completion.
// (R04) Stop and completion come from origin, index pulse or end-limit inputs.
// (R05) Origin input is active low when config A bit 7 is 0, high when 1.
// (R06) Sub status bit 14 shows origin state after polarity, 1 meaning on.
// (R07) Index pulses count on falling edges if config B bit 23 is 0, else rising.
// (R08) Config C bits 7:4 hold index count minus one; reaching it completes.
// (R09) Extended status bit 10 shows the current index input, 1 while on.
// (R10) A pin sets end-limit polarity: low positive logic, high negative logic.
// (R11) End limit on stops with deceleration if config A bit 3 is 1, else immediately.
// (R12) Sub status bits 12 and 13 show positive and negative end limit, 1 on.
// (R13) Config A bit 26 filters origin and end limits, ignoring pulses under 4 us.
// (R14) Finished zero return clears position and pulses deviation clear when enabled.
`timescale 1ns/1ps
module azp_top
	import azp_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [31:0] reg_rdata_o,
	input wire azp_pkg::azp_sensor_s sensor_i,
	output logic axis_run_o,
	output logic axis_dir_pos_o,
	output logic axis_decel_stop_o,
	output logic axis_immediate_stop_o,
	output logic axis_done_o,
	output logic position_clear_o,
	output logic deviation_clear_out_o
);
	import azp_pkg::*;

	function automatic azp_kind_e op_kind(input logic [6:0] code);
		unique case (code)
			OP_RETURN_POS, OP_RETURN_NEG: op_kind = KIND_RETURN;
			OP_LEAVE_POS, OP_LEAVE_NEG: op_kind = KIND_LEAVE;
			OP_SEARCH_POS, OP_SEARCH_NEG: op_kind = KIND_SEARCH;
			default: op_kind = KIND_NONE;
		endcase
	endfunction

	// Bit 3 of every zero position code marks the negative direction.
	function automatic logic op_dir_pos(input logic [6:0] code);
		op_dir_pos = ~code[3];
	endfunction

	logic [31:0] env_a_q;
	logic [31:0] env_b_q;
	logic [31:0] env_c_q;
	logic [6:0] opcode_q;
	azp_sensor_s sync1_q;
	azp_sensor_s sync2_q;
	azp_sensor_s sync3_q;
	azp_sensor_s clean_q;
	logic [4:0] filt_q;
	logic [6:0] filt_cnt_q [0:4];
	logic index_prev_q;
	azp_state_e state_q;
	azp_kind_e kind_q;
	logic [3:0] idx_cnt_q;
	logic limit_err_q;
	logic [31:0] rdata_q;

	logic origin_on;
	logic limit_pos_on;
	logic limit_neg_on;
	logic index_on;
	logic index_edge;
	logic limit_hit;
	logic start_acc;
	logic abort_acc;
	logic [3:0] idx_target;
	logic done_now;
	logic done_return;

	// Only two of the three stages agree before a change is taken, so one-cycle noise is lost.
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
			sync3_q <= '0;
			clean_q <= '0;
			index_prev_q <= 1'b0;
		end
		else
		begin
			sync1_q <= sensor_i;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			index_prev_q <= index_on;
			for (int i = 0; i < 5; i++)
			begin
				if (sync2_q[i] == sync3_q[i])
				begin
					clean_q[i] <= sync3_q[i];
				end
			end
		end
	end

	// The filter delays every real change by the full window; that latency is the price of it.
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			filt_q <= '0;
			for (int i = 0; i < 5; i++)
			begin
				filt_cnt_q[i] <= 7'h00;
			end
		end
		else
		begin
			for (int i = 0; i < 5; i++)
			begin
				if (!env_a_q[ENV_A_FILTER_EN] || i == 1 || i == 4)
				begin
					filt_q[i] <= clean_q[i];
					filt_cnt_q[i] <= 7'h00;
				end
				else if (clean_q[i] == filt_q[i])
				begin
					filt_cnt_q[i] <= 7'h00;
				end
				else if (filt_cnt_q[i] == FILTER_CYCLES - 7'h01)
				begin
					filt_q[i] <= clean_q[i]; // R13
					filt_cnt_q[i] <= 7'h00;
				end
				else
				begin
					filt_cnt_q[i] <= filt_cnt_q[i] + 7'h01;
				end
			end
		end
	end

	assign origin_on = env_a_q[ENV_A_ORIGIN_POL] ? filt_q[0] : ~filt_q[0]; // R05
	assign limit_pos_on = clean_q.limit_sel_neg ? ~filt_q[2] : filt_q[2]; // R10
	assign limit_neg_on = clean_q.limit_sel_neg ? ~filt_q[3] : filt_q[3]; // R10
	assign index_on = clean_q.index;
	assign index_edge = env_b_q[ENV_B_INDEX_RISING] ? (index_on & ~index_prev_q)
		: (~index_on & index_prev_q); // R07
	assign idx_target = env_c_q[ENV_C_TARGET_LSB +: 4];
	assign limit_hit = axis_dir_pos_o ? limit_pos_on : limit_neg_on; // R04
	assign start_acc = reg_we_i && reg_addr_i == ADDR_CONTROL && reg_wdata_i[CTRL_START]
		&& state_q == ST_IDLE && op_kind(reg_wdata_i[6:0]) != KIND_NONE;
	assign abort_acc = reg_we_i && reg_addr_i == ADDR_CONTROL && reg_wdata_i[CTRL_ABORT]
		&& state_q != ST_IDLE;

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			env_a_q <= ENV_A_RESET;
			env_b_q <= ENV_B_RESET;
			env_c_q <= ENV_C_RESET;
			opcode_q <= OPCODE_RESET;
		end
		else if (reg_we_i)
		begin
			unique case (reg_addr_i)
				ADDR_ENV_A: env_a_q <= reg_wdata_i;
				ADDR_ENV_B: env_b_q <= reg_wdata_i;
				ADDR_ENV_C: env_c_q <= reg_wdata_i;
				ADDR_CONTROL: opcode_q <= reg_wdata_i[6:0];
				default: ;
			endcase
		end
	end

	always_comb
	begin
		done_now = 1'b0;
		if (!abort_acc && !limit_hit)
		begin
			unique case (state_q)
				ST_FEED: done_now = (kind_q == KIND_LEAVE && !origin_on)
					|| (kind_q == KIND_RETURN && origin_on
					&& !env_c_q[ENV_C_RETURN_USE_INDEX]); // R04
				ST_COUNT: done_now = index_edge && idx_cnt_q == idx_target; // R08
				default: done_now = 1'b0;
			endcase
		end
	end
	assign done_return = done_now && kind_q == KIND_RETURN;

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			state_q <= ST_IDLE;
			kind_q <= KIND_NONE;
			idx_cnt_q <= 4'h0;
			axis_dir_pos_o <= 1'b1;
		end
		else if (start_acc)
		begin
			state_q <= ST_FEED;
			kind_q <= op_kind(reg_wdata_i[6:0]);
			axis_dir_pos_o <= op_dir_pos(reg_wdata_i[6:0]); // R01 R02 R03
			idx_cnt_q <= 4'h0;
		end
		else if (abort_acc || limit_hit || done_now)
		begin
			state_q <= ST_IDLE;
		end
		else
		begin
			unique case (state_q)
				ST_FEED:
				begin
					if (origin_on && kind_q != KIND_LEAVE)
					begin
						state_q <= ST_COUNT;
					end
				end
				ST_COUNT:
				begin
					if (index_edge)
					begin
						idx_cnt_q <= idx_cnt_q + 4'h1;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end
	assign axis_run_o = state_q != ST_IDLE;

	// A limit hit while running and an accepted start never share a cycle: start is only taken in idle.
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			axis_decel_stop_o <= 1'b0;
			axis_immediate_stop_o <= 1'b0;
			axis_done_o <= 1'b0;
			position_clear_o <= 1'b0;
			deviation_clear_out_o <= 1'b0;
			limit_err_q <= 1'b0;
		end
		else
		begin
			axis_decel_stop_o <= axis_run_o && limit_hit && env_a_q[ENV_A_LIMIT_DECEL]; // R11
			axis_immediate_stop_o <= axis_run_o && ((limit_hit && !env_a_q[ENV_A_LIMIT_DECEL])
				|| abort_acc || done_now); // R11
			axis_done_o <= done_now;
			position_clear_o <= done_return && env_c_q[ENV_C_COUNTER_RST_EN]; // R14
			deviation_clear_out_o <= done_return && env_a_q[ENV_A_CLEAR_OUT_EN]; // R14
			if (axis_run_o && limit_hit)
			begin
				limit_err_q <= 1'b1;
			end
			else if (start_acc)
			begin
				limit_err_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i || !reg_re_i)
		begin
			rdata_q <= 32'h0000_0000;
		end
		else
		begin
			unique case (reg_addr_i)
				ADDR_ENV_A: rdata_q <= env_a_q;
				ADDR_ENV_B: rdata_q <= env_b_q;
				ADDR_ENV_C: rdata_q <= env_c_q;
				ADDR_CONTROL: rdata_q <= {25'h0000000, opcode_q};
				ADDR_SUB_STATUS: rdata_q <= {17'h00000, origin_on, limit_neg_on, limit_pos_on,
					11'h000, axis_run_o}; // R06 R12
				ADDR_EXT_STATUS: rdata_q <= {21'h000000, index_on, 5'h00, limit_err_q,
					2'h0, state_q}; // R09
				default: rdata_q <= 32'h0000_0000;
			endcase
		end
	end
	assign reg_rdata_o = rdata_q;

	a_dir_leave: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R01
		start_acc && reg_wdata_i[6:0] == OP_LEAVE_NEG |=> axis_run_o && !axis_dir_pos_o)
		else $error("leave negative did not start negative");
	a_dir_search: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R02
		start_acc && reg_wdata_i[6:0] == OP_SEARCH_POS |=> axis_run_o && axis_dir_pos_o)
		else $error("search positive did not start positive");
	a_dir_return: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R03
		start_acc && reg_wdata_i[6:0] == OP_RETURN_NEG |=> !axis_dir_pos_o
		&& state_q == ST_FEED && kind_q == KIND_RETURN)
		else $error("return negative did not feed negative");
	a_leave_done: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R04
		state_q == ST_FEED && kind_q == KIND_LEAVE && !origin_on && !limit_hit && !abort_acc
		|=> axis_done_o && !axis_run_o)
		else $error("leave did not end on origin off");
	a_origin_read: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R05 R06
		reg_re_i && reg_addr_i == ADDR_SUB_STATUS
		|=> reg_rdata_o[SUB_ORIGIN] == ($past(env_a_q[ENV_A_ORIGIN_POL]) ~^ $past(filt_q[0])))
		else $error("origin status wrong");
	a_index_read: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R09
		reg_re_i && reg_addr_i == ADDR_EXT_STATUS
		|=> reg_rdata_o[EXT_INDEX_STATE] == $past(clean_q.index))
		else $error("index status wrong");
	a_index_count: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R07 R08
		state_q == ST_COUNT && index_edge && idx_cnt_q != idx_target && !limit_hit && !abort_acc
		|=> state_q == ST_COUNT && idx_cnt_q == $past(idx_cnt_q) + 4'h1)
		else $error("index count did not advance");
	a_limit_stop: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R10 R11
		axis_run_o && limit_hit |=> !axis_run_o
		&& axis_decel_stop_o == $past(env_a_q[ENV_A_LIMIT_DECEL])
		&& axis_immediate_stop_o == !$past(env_a_q[ENV_A_LIMIT_DECEL]))
		else $error("limit stop wrong");
	a_limit_read: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R12
		reg_re_i && reg_addr_i == ADDR_SUB_STATUS
		|=> reg_rdata_o[SUB_LIMIT_NEG:SUB_LIMIT_POS] == $past({limit_neg_on, limit_pos_on}))
		else $error("limit status wrong");
	a_filter_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R13
		env_a_q[ENV_A_FILTER_EN] && clean_q.origin != filt_q[0]
		&& filt_cnt_q[0] < FILTER_CYCLES - 7'h01 |=> $stable(filt_q[0]))
		else $error("filter passed a short pulse");
	a_clear_gate: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R14
		position_clear_o || deviation_clear_out_o |-> axis_done_o && $past(kind_q) == KIND_RETURN)
		else $error("clear outside a finished return");
endmodule

// [dv/azp_sensor_model.sv]
// Sensor-side model: turns the logical sensor states into pin levels.
`timescale 1ns/1ps
module azp_sensor_model
	import azp_pkg::*;
(
	input wire logic origin_on_i,
	input wire logic index_on_i,
	input wire logic limit_pos_on_i,
	input wire logic limit_neg_on_i,
	input wire logic origin_high_i,
	input wire logic limit_sel_neg_i,
	output azp_pkg::azp_sensor_s pins_o
);
	// The origin pin idles at the inactive level of whichever polarity is chosen.
	assign pins_o.origin = origin_on_i ~^ origin_high_i;
	assign pins_o.index = index_on_i;
	assign pins_o.limit_pos = limit_pos_on_i ^ limit_sel_neg_i;
	assign pins_o.limit_neg = limit_neg_on_i ^ limit_sel_neg_i;
	assign pins_o.limit_sel_neg = limit_sel_neg_i;
endmodule

// [dv/tb.sv]
// Self-checking bench for the axis zero position block.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("wrong value t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
	import azp_pkg::*;
	localparam logic [31:0] GO = 32'h1 << CTRL_START;
	localparam logic [31:0] STOP = 32'h1 << CTRL_ABORT;
	logic ref_clk_i = 1'b0, rst_i = 1'b1, reg_we_i = 1'b0, reg_re_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, rd, v;
	logic run, dir, dstop, istop, done, pclr, dclr, edge_sel;
	logic org_on = 1'b0, idx_on = 1'b0, lp_on = 1'b0, ln_on = 1'b0, org_hi = 1'b0, lsel = 1'b0;
	azp_sensor_s pins;
	logic [6:0] codes [6] = '{OP_RETURN_POS, OP_RETURN_NEG, OP_LEAVE_POS, OP_LEAVE_NEG,
		OP_SEARCH_POS, OP_SEARCH_NEG};
	int n_fail = 0, n_checks = 0, cyc = 0, n_dst = 0, n_ist = 0, n_done = 0;
	int n_pclr = 0, n_dclr = 0, n0, s0, i0, p0, c0, tgt;
	logic [31:0] seed = 32'h0000_0062;

	azp_sensor_model sens (.origin_on_i(org_on), .index_on_i(idx_on), .limit_pos_on_i(lp_on),
		.limit_neg_on_i(ln_on), .origin_high_i(org_hi), .limit_sel_neg_i(lsel), .pins_o(pins));
	azp_top dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
		.reg_rdata_o(reg_rdata_o), .sensor_i(pins), .axis_run_o(run), .axis_dir_pos_o(dir),
		.axis_decel_stop_o(dstop), .axis_immediate_stop_o(istop), .axis_done_o(done),
		.position_clear_o(pclr), .deviation_clear_out_o(dclr));

	initial
	begin
		forever #20 ref_clk_i = ~ref_clk_i;
	end

	// Pulses are tallied on the falling edge, well clear of their launching edge.
	always @(negedge ref_clk_i)
	begin
		cyc++;
		n_dst += int'(dstop);
		n_ist += int'(istop);
		n_done += int'(done);
		n_pclr += int'(pclr);
		n_dclr += int'(dclr);
		if (cyc == 20000)
		begin
			n_fail++;
			tally_and_finish();
		end
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic wait_n(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_we_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_we_i <= 1'b0;
		#1;
	endtask

	// Read data only stand in the cycle after the strobe, so they are taken there.
	task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_re_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_re_i <= 1'b0;
		#1;
		rd = reg_rdata_o & m;
		`CHK(rd, e)
	endtask

	task automatic ipulse();
		idx_on = 1'b1;
		wait_n(6);
		idx_on = 1'b0;
		wait_n(6);
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (4) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		for (int a = 0; a < 12; a += 4)
			rdchk(8'(a), '1, 32'h0);
		rdchk(8'h20, '1, 32'h0);
		wr(ADDR_ENV_B, 32'h1234_5678);
		rdchk(ADDR_ENV_B, '1, 32'h1234_5678);
		for (int k = 0; k < 4; k++)
		begin
			org_hi = k[1];
			org_on = k[0];
			wr(ADDR_ENV_A, 32'(k[1]) << ENV_A_ORIGIN_POL);
			wait_n(8);
			rdchk(ADDR_SUB_STATUS, 32'h4000, 32'(k[0]) << SUB_ORIGIN);
		end
		for (int k = 0; k < 8; k++)
		begin
			{lsel, ln_on, lp_on} = 3'(k);
			wait_n(8);
			rdchk(ADDR_SUB_STATUS, 32'h3000, 32'(k & 3) << SUB_LIMIT_POS);
		end
		{ln_on, lp_on} = 2'b00;
		for (int k = 0; k < 2; k++)
		begin
			idx_on = k[0];
			wait_n(8);
			rdchk(ADDR_EXT_STATUS, 32'h400, 32'(k) << EXT_INDEX_STATE);
		end
		idx_on = 1'b0;
		org_on = 1'b0;
		wr(ADDR_ENV_A, (32'h1 << ENV_A_FILTER_EN) | (32'h1 << ENV_A_ORIGIN_POL));
		wait_n(120);
		org_on = 1'b1;
		wait_n(50);
		org_on = 1'b0;
		wait_n(10);
		rdchk(ADDR_SUB_STATUS, 32'h4000, 32'h0);
		org_on = 1'b1;
		wait_n(110);
		rdchk(ADDR_SUB_STATUS, 32'h4000, 32'h4000);
		org_on = 1'b0;
		wait_n(110);
		wr(ADDR_ENV_A, 32'h1 << ENV_A_ORIGIN_POL);
		foreach (codes[j])
		begin
			n0 = n_done;
			wr(ADDR_CONTROL, GO | 32'(codes[j]));
			// The code table lists each operation positive first, then negative.
			`CHK({run, dir}, {1'b1, 1'(j % 2 == 0)})
			wait_n(10);
			`CHK(n_done - n0, int'(j == 2 || j == 3))
			wr(ADDR_CONTROL, STOP);
			wait_n(4);
			`CHK(run, 1'b0)
		end
		for (int k = 0; k < 2; k++)
		begin
			wr(ADDR_ENV_C, (32'(k) << ENV_C_COUNTER_RST_EN)
				| (32'(k) << ENV_C_RETURN_USE_INDEX));
			wr(ADDR_ENV_A, (32'h1 << ENV_A_ORIGIN_POL) | (32'(k) << ENV_A_CLEAR_OUT_EN));
			{n0, p0, c0} = {n_done, n_pclr, n_dclr};
			wr(ADDR_CONTROL, GO | 32'(OP_RETURN_NEG));
			wait_n(3);
			org_on = 1'b1;
			wait_n(10);
			// With the index method the origin only arms the count; one falling edge ends it.
			`CHK(n_done - n0, 1 - k)
			if (k == 1)
				ipulse();
			`CHK(n_done - n0, 1)
			`CHK(n_pclr - p0, k)
			`CHK(n_dclr - c0, k)
			org_on = 1'b0;
			wait_n(8);
		end
		for (int k = 0; k < 2; k++)
		begin
			wr(ADDR_ENV_A, (32'h1 << ENV_A_ORIGIN_POL) | (32'(k) << ENV_A_LIMIT_DECEL));
			{s0, i0} = {n_dst, n_ist};
			wr(ADDR_CONTROL, GO | 32'(OP_SEARCH_NEG));
			wait_n(3);
			ln_on = 1'b1;
			wait_n(10);
			`CHK(n_dst - s0, k)
			`CHK(n_ist - i0, 1 - k)
			`CHK(run, 1'b0)
			ln_on = 1'b0;
			wait_n(8);
		end
		wr(ADDR_ENV_C, 32'h0);
		repeat (3)
		begin
			v = xs();
			tgt = int'(v[3:0]);
			edge_sel = v[8];
			wr(ADDR_ENV_B, 32'(edge_sel) << ENV_B_INDEX_RISING);
			wr(ADDR_ENV_C, 32'(v[3:0]) << ENV_C_TARGET_LSB);
			n0 = n_done;
			wr(ADDR_CONTROL, GO | 32'(OP_SEARCH_POS));
			wait_n(3);
			org_on = 1'b1;
			wait_n(10);
			repeat (tgt) ipulse();
			`CHK(n_done - n0, 0)
			`CHK(run, 1'b1)
			// Holding the index high tells the two edge choices apart.
			idx_on = 1'b1;
			wait_n(8);
			`CHK(n_done - n0, int'(edge_sel))
			idx_on = 1'b0;
			wait_n(8);
			`CHK(n_done - n0, 1)
			org_on = 1'b0;
			wait_n(8);
		end
		tally_and_finish();
	end
endmodule
